// ===== frame_sync_pkg.sv
`default_nettype none
package frame_sync_pkg;

  // ---------------------------------------------------------------
  // Frame geometry
  // ---------------------------------------------------------------
  localparam int unsigned SLOT_BITS   = 8;
  localparam int unsigned FRAME_BITS  = 256;
  localparam logic [7:0]  BIT_LAST    = 8'hFF;
  localparam logic [7:0]  BIT_SLOT_ZERO_END  = 8'h07;  // Last bit of slot zero
  localparam logic [7:0]  BIT_SLOT_ONE_FIRST = 8'h08;  // First bit of slot one

  // Sync word pattern for bits 2 to 8, bit 2 first on the wire
  localparam logic [6:0]  SYNC_WORD   = 7'h1B;
  localparam logic [1:0]  ERR_LOSS    = 2'h3;    // Errored sync frames to lose sync
  localparam logic [1:0]  GOOD_REGAIN = 2'h3;    // Good frames to regain sync
  localparam logic [1:0]  ERR_FLAG    = 2'h2;    // Errored sync frames to raise error

  // Clock rate kept for reference; the link runs one bit per clock
  localparam int unsigned CLK_KHZ     = 2048;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       sync_bit_one;
    logic       nonsync_bit_one;
    logic [5:0] spare_bits;
  } spare_bits_t;

  typedef enum logic [1:0] {
    ST_SEARCH = 2'b01,
    ST_LOCKED = 2'b10
  } align_state_t;

endpackage : frame_sync_pkg
`default_nettype wire

// ===== pcm_frame_sync_assertions.sv
`default_nettype none
// ---------------------------------------
// Port checks for the frame sync receiver
// ---------------------------------------
module pcm_frame_sync_checker (
  input wire logic                        sys_clk_in,
  input wire logic                        rstn_in,
  input wire logic                        slot_zero_pulse_out,
  input wire logic                        channel_reset_n_out,
  input wire logic                        error_out,
  input wire logic                        sync_alarm_out,
  input wire frame_sync_pkg::spare_bits_t spare_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking chk_cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  // Search may realign mid pulse, so width is judged only while locked
  sequence s_pulse_body;
    slot_zero_pulse_out[*8] ##1 !slot_zero_pulse_out;
  endsequence
  a_pulse_width: assert property ($rose(slot_zero_pulse_out) && !sync_alarm_out |-> s_pulse_body)
    else $error("slot zero pulse width wrong");
  a_chrst_single: assert property (!channel_reset_n_out |=> channel_reset_n_out)
    else $error("channel reset longer than one clock");
  a_chrst_place: assert property ($fell(channel_reset_n_out) |-> $past(slot_zero_pulse_out, 2))
    else $error("channel reset away from slot zero end");
  a_chrst_locked: assert property ($fell(channel_reset_n_out) |-> !sync_alarm_out || !$past(sync_alarm_out))
    else $error("channel reset while out of sync");
  a_chrst_on_loss: assert property ($rose(sync_alarm_out) |-> $past(channel_reset_n_out))
    else $error("channel reset pulsed as sync was lost");
  a_alarm_at_end: assert property ($changed(sync_alarm_out) |-> $past(slot_zero_pulse_out, 2))
    else $error("alarm moved away from pulse end");
  a_error_first: assert property ($rose(sync_alarm_out) |-> error_out)
    else $error("alarm raised without error");
  a_error_hold: assert property (sync_alarm_out && error_out |=> error_out || !sync_alarm_out)
    else $error("error dropped during alarm");
  a_error_at_end: assert property ($changed(error_out) |-> $past(slot_zero_pulse_out, 2))
    else $error("error moved away from pulse end");
  a_spare_moment: assert property ($changed(spare_out) |->
    $past(slot_zero_pulse_out, 2) || $past(slot_zero_pulse_out, 3))
    else $error("spare outputs moved outside slot one");
endmodule : pcm_frame_sync_checker
`default_nettype wire

// ===== pcm_frame_sync_receiver.sv
`default_nettype none
module pcm_frame_sync_receiver (
  input  wire logic                         sys_clk_in,
  input  wire logic                         rstn_in,
  input  wire logic                         data_in,
  output logic                              slot_zero_pulse_out,
  output logic                              channel_reset_n_out,
  output logic                              error_out,
  output logic                              sync_alarm_out,
  output frame_sync_pkg::spare_bits_t       spare_out
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Detector
  // ---------------------------------------------------------------
  logic [7:0] window;
  logic       match;

  sync_word_detect sync_word_detect_inst (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_n_ff),
    .data_in    (data_in),
    .window_out (window),
    .match_out  (match)
  );

  // ---------------------------------------------------------------
  // Frame counter and alignment
  // ---------------------------------------------------------------
  frame_sync_pkg::align_state_t state_ff;
  logic [7:0] bit_cnt_ff;     // 0 means bit one of slot zero is the newest bit in the window
  logic       sync_frame_ff;  // Frame just ended in slot zero was a sync frame
  logic [1:0] err_cnt_ff;
  logic [1:0] good_cnt_ff;
  logic       err_pend_ff;    // One errored sync frame seen, awaiting the next

  logic slot_end;
  logic expect_sync;
  logic sync_ok;
  logic nonsync_ok;
  logic loss_now;

  // Slot zero has fully entered the window when the counter reaches BIT_SLOT_ZERO_END
  assign slot_end    = (bit_cnt_ff == frame_sync_pkg::BIT_SLOT_ZERO_END);
  assign expect_sync = ~sync_frame_ff;
  assign sync_ok     = match;
  assign nonsync_ok  = window[6];
  // This errored sync word is the one that drops lock at this slot end
  assign loss_now    = expect_sync && !sync_ok &&
                       (err_cnt_ff + 2'h1 == frame_sync_pkg::ERR_LOSS);

  // Counter free-runs; in search it is forced onto any match not at slot end
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      bit_cnt_ff <= 8'h00;
    end else if (state_ff == frame_sync_pkg::ST_SEARCH && match && !slot_end) begin
      bit_cnt_ff <= frame_sync_pkg::BIT_SLOT_ONE_FIRST;
    end else begin
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
    end
  end

  // Alternation flag flips each frame, reloaded on a search hit
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync_frame_ff <= 1'b0;
    end else if (state_ff == frame_sync_pkg::ST_SEARCH && match) begin
      sync_frame_ff <= 1'b1;
    end else if (slot_end) begin
      sync_frame_ff <= expect_sync;
    end
  end

  // Errored and good frame tallies, evaluated at each slot zero end
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      err_cnt_ff  <= 2'h0;
      good_cnt_ff <= 2'h0;
      err_pend_ff <= 1'b0;
      state_ff    <= frame_sync_pkg::ST_SEARCH;
    end else if (slot_end) begin
      if (expect_sync && !sync_ok) begin
        good_cnt_ff <= 2'h0;
        err_pend_ff <= 1'b1;
        if (err_cnt_ff != frame_sync_pkg::ERR_LOSS) begin
          err_cnt_ff <= err_cnt_ff + 2'h1;
        end
        if (err_cnt_ff + 2'h1 == frame_sync_pkg::ERR_LOSS) begin
          state_ff <= frame_sync_pkg::ST_SEARCH;
        end
      end else if (expect_sync || nonsync_ok) begin
        if (expect_sync) begin
          err_cnt_ff  <= 2'h0;
          err_pend_ff <= 1'b0;
        end
        if (state_ff == frame_sync_pkg::ST_SEARCH) begin
          good_cnt_ff <= good_cnt_ff + 2'h1;
          if (good_cnt_ff + 2'h1 == frame_sync_pkg::GOOD_REGAIN) begin
            state_ff    <= frame_sync_pkg::ST_LOCKED;
            good_cnt_ff <= 2'h0;
          end
        end
      end else begin
        good_cnt_ff <= 2'h0;                               // Bad non-sync frame restarts count
      end
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  // Alarm and error track the tallies; registered for clean edges
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync_alarm_out <= 1'b1;
      error_out      <= 1'b0;
    end else begin
      sync_alarm_out <= (state_ff == frame_sync_pkg::ST_SEARCH);
      if (state_ff == frame_sync_pkg::ST_SEARCH && slot_end && !(expect_sync || nonsync_ok)) begin
        error_out <= 1'b1;
      end else if (slot_end && expect_sync) begin
        // Second errored sync frame raises it; a good one clears outside alarm
        if (!sync_ok && err_pend_ff) begin
          error_out <= 1'b1;
        end else if (sync_ok && state_ff == frame_sync_pkg::ST_LOCKED) begin
          error_out <= 1'b0;
        end
      end else if (state_ff == frame_sync_pkg::ST_LOCKED && err_cnt_ff == 2'h0 && !err_pend_ff) begin
        error_out <= 1'b0;
      end
    end
  end

  // Slot zero pulse: eight clocks, one bit after slot zero starts
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      slot_zero_pulse_out <= 1'b0;
    end else begin
      slot_zero_pulse_out <= (bit_cnt_ff < frame_sync_pkg::BIT_SLOT_ZERO_END) ||
                             (bit_cnt_ff == frame_sync_pkg::BIT_LAST);
    end
  end

  // Channel reset low one clock after slot zero of sync frames, only when locked
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      channel_reset_n_out <= 1'b1;
    end else begin
      // Sync is already gone when the word that loses it ends, so no reset then
      channel_reset_n_out <= ~(slot_end && expect_sync && !loss_now &&
                               state_ff == frame_sync_pkg::ST_LOCKED);
    end
  end

  // ---------------------------------------------------------------
  // Spare bits
  // ---------------------------------------------------------------
  logic [7:0] slot_cap_ff;
  logic       cap_sync_ff;
  logic       cap_valid_ff;

  // Slot zero is captured at its end and published at the falling edge in slot one
  always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      slot_cap_ff  <= 8'h00;
      cap_sync_ff  <= 1'b0;
      cap_valid_ff <= 1'b0;
    end else begin
      cap_valid_ff <= slot_end;
      if (slot_end) begin
        slot_cap_ff <= window;
        cap_sync_ff <= expect_sync;
      end
    end
  end

  // Falling edge keeps the single clock; it only retimes flip-flop data
  always_ff @(negedge sys_clk_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      spare_out <= '0;
    end else if (cap_valid_ff) begin
      if (cap_sync_ff) begin
        spare_out.sync_bit_one <= slot_cap_ff[7];
      end else begin
        spare_out.nonsync_bit_one <= slot_cap_ff[7];
        spare_out.spare_bits      <= slot_cap_ff[5:0];
      end
    end
  end

endmodule : pcm_frame_sync_receiver
`default_nettype wire

// ===== pcm_line_source.sv
`default_nettype none
// ---------------------------
// Upstream line decoder model
// ---------------------------
module pcm_line_source (
  input  wire logic                        clk_in,
  input  wire logic                        bad_in,
  input  wire frame_sync_pkg::spare_bits_t sp_in,
  output logic                             data_out,
  output logic                             sync_frame_out,
  output logic                             frame_end_out,
  output logic                             slot0_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] bit_ff = 8'hFF;
  logic       par_ff = 1'h0;
  logic [7:0] word;
  // Bit counter over 256-bit frames; sync and non-sync frames alternate
  always @(posedge clk_in) begin
    bit_ff <= bit_ff + 8'h01;
    if (bit_ff == 8'hFF) par_ff <= !par_ff;
  end
  // Slot zero word, bit one first; payload stays at ones so searching finds no false word
  assign word = par_ff ? {sp_in.sync_bit_one, frame_sync_pkg::SYNC_WORD ^ {6'h00, bad_in}}
                       : {sp_in.nonsync_bit_one, !bad_in, sp_in.spare_bits};
  assign data_out       = (bit_ff < 8'h08) ? word[3'h7 - bit_ff[2:0]] : 1'h1;
  assign sync_frame_out = par_ff;
  assign frame_end_out  = (bit_ff == 8'hFF);
  assign slot0_done_out = (bit_ff == frame_sync_pkg::BIT_SLOT_ZERO_END);
endmodule : pcm_line_source
`default_nettype wire

// ===== sync_word_detect.sv
`default_nettype none
// ---------------------------------------------------------------
// Serial to parallel register and sync word comparator
// ---------------------------------------------------------------
module sync_word_detect (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       data_in,
  output logic [7:0]      window_out,
  output logic            match_out
);

  logic [7:0] serial_to_parallel_register_ff;

  // Oldest bit sits at the top, so [7] is slot bit 1 after eight shifts
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_to_parallel_register_ff <= 8'h00;
    end else begin
      serial_to_parallel_register_ff <= {serial_to_parallel_register_ff[6:0], data_in};
    end
  end

  assign window_out = serial_to_parallel_register_ff;
  // Bit one is spare, so only the low seven are compared
  assign match_out  = (serial_to_parallel_register_ff[6:0] == frame_sync_pkg::SYNC_WORD);

endmodule : sync_word_detect
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic                        chk;
    frame_sync_pkg::spare_bits_t sp;
    logic                        err;
    logic                        alm;
    logic                        cr;
  } note_t;
  logic                        sys_clk_in, rstn_in, line_data, bad, sync_fr, fend, s0done;
  logic                        pulse, chrst_n, err_o, alm_o, chk_on;
  frame_sync_pkg::spare_bits_t sp, spo;
  note_t                       e;
  note_t                       notes[$];
  int                          fails = 0;
  int                          n_checks = 0;
  int                          ecnt = 0;
  int                          seed = 32'h306E;
  pcm_frame_sync_receiver pcm_frame_sync_receiver_inst (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .data_in(line_data), .slot_zero_pulse_out(pulse), .channel_reset_n_out(chrst_n), .error_out(err_o),
    .sync_alarm_out(alm_o), .spare_out(spo));
  pcm_line_source pcm_line_source_inst (.clk_in(sys_clk_in), .bad_in(bad), .sp_in(sp), .data_out(line_data),
    .sync_frame_out(sync_fr), .frame_end_out(fend), .slot0_done_out(s0done));
  // ----------------
  // Clock and checks
  // ----------------
  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = !sys_clk_in;
  end
  task automatic cmp_lvl(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_lvl
  task automatic cmp_spare(input frame_sync_pkg::spare_bits_t exp, input frame_sync_pkg::spare_bits_t got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] spare_out expected %h seen %h", exp, got);
    end
  endtask : cmp_spare
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Sets the next frame's content at frame end and notes what it should leave behind
  task automatic next_frame(input logic bad_f);
    int          k;
    logic [31:0] r;
    k = 0;
    do begin
      @(posedge sys_clk_in);
      #1;
      k++;
    end while (fend !== 1'h1 && k < 300);
    if (k >= 300) begin
      fails++;
      give_verdict();
    end else begin
      r = $random(seed);
      sp = (ecnt == 0 && chk_on) ? r[7:0] : {r[7:6], 6'h3F};
      // Non-sync frames get a bad bit two too; only sync words may move the tallies
      bad = bad_f;
      e.chk = chk_on;
      e.cr = 1'h1;
      if (!sync_fr) begin
        e.sp.sync_bit_one = sp.sync_bit_one;
        ecnt = bad ? ecnt + 1 : 0;
        if (ecnt != 1) e.err = (ecnt >= 2);
        e.alm = (ecnt >= 3);
        e.cr = (ecnt >= 3);
      end else begin
        e.sp.nonsync_bit_one = sp.nonsync_bit_one;
        e.sp.spare_bits = sp.spare_bits;
      end
      notes.push_back(e);
      if (ecnt >= 3) chk_on = 1'h0;
    end
  endtask : next_frame
  // Watcher: six clocks past each slot zero the outputs have settled
  initial begin
    note_t n;
    forever begin
      @(posedge sys_clk_in);
      if (s0done === 1'h1 && notes.size() > 0) begin
        n = notes.pop_front();
        #1;
        if (n.chk) cmp_lvl("slot_zero_pulse_out", 1'h1, pulse);
        @(posedge sys_clk_in);
        #1;
        if (n.chk) begin
          cmp_lvl("slot_zero_pulse_out", 1'h0, pulse);
          cmp_lvl("channel_reset_n_out", n.cr, chrst_n);
        end
        @(posedge sys_clk_in);
        #1;
        if (n.chk) cmp_lvl("channel_reset_n_out", 1'h1, chrst_n);
        repeat (4) @(posedge sys_clk_in);
        #1;
        if (n.chk) begin
          cmp_spare(n.sp, spo);
          cmp_lvl("error_out", n.err, err_o);
          cmp_lvl("sync_alarm_out", n.alm, alm_o);
        end
      end
    end
  end
  // Lock, error run ending in loss, then regain
  initial begin
    int         i;
    logic [9:0] bad_seq;
    bad_seq = 10'h0B7;
    rstn_in = 1'h0;
    bad = 1'h0;
    sp = 8'hFF;
    e = {1'h0, 8'hFF, 3'h3};
    chk_on = 1'h0;
    repeat (12) @(posedge sys_clk_in);
    #1;
    cmp_lvl("slot_zero_pulse_out", 1'h0, pulse);
    cmp_lvl("channel_reset_n_out", 1'h1, chrst_n);
    cmp_lvl("sync_alarm_out", 1'h1, alm_o);
    rstn_in = 1'h1;
    for (i = 0; i < 12 && alm_o !== 1'h0; i++) next_frame(1'h0);
    cmp_lvl("sync_alarm_out", 1'h0, alm_o);
    repeat (2) next_frame(1'h0);
    chk_on = 1'h1;
    for (i = 9; i >= 0; i--) repeat (2) next_frame(bad_seq[i]);
    for (i = 0; i < 12 && alm_o !== 1'h0; i++) next_frame(1'h0);
    cmp_lvl("sync_alarm_out", 1'h0, alm_o);
    repeat (2) next_frame(1'h0);
    chk_on = 1'h1;
    repeat (4) next_frame(1'h0);
    repeat (20) @(posedge sys_clk_in);
    give_verdict();
  end
endmodule : tb_top
bind pcm_frame_sync_receiver pcm_frame_sync_checker pcm_frame_sync_checker_inst (.sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in), .slot_zero_pulse_out(slot_zero_pulse_out), .channel_reset_n_out(channel_reset_n_out),
  .error_out(error_out), .sync_alarm_out(sync_alarm_out), .spare_out(spare_out));
`default_nettype wire
